// ### inc/ime_pkg.sv
package ime_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [1:0] ADR_BUF = 2'h0;
    localparam logic [1:0] ADR_RLD = 2'h1;
    localparam logic [1:0] ADR_CTL = 2'h2;
    localparam logic [1:0] ADR_STA = 2'h3;

    // control_register_two bit positions
    localparam int C_STP = 2;
    localparam int C_RCV = 3;
    localparam int C_ACK = 4;
    localparam int C_AKD = 5;
    localparam int C_AKS = 6;

    // port_status_register bit positions
    localparam int S_BF = 0;
    localparam int S_EVT = 1;
    localparam int S_WRITE_COLLISION_FLAG = 2;
    localparam int S_OV = 3;
    localparam int S_STOP = 4;

    // ********************************
    // counts and reset values
    // ********************************
    localparam logic [6:0] RLD_RST = 7'h04;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [2:0] SYNC_RST = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_TXL = 4'h1,
        ST_TXH = 4'h2,
        ST_RXL = 4'h3,
        ST_RXH = 4'h4,
        ST_AKL = 4'h5,
        ST_AKH = 4'h6,
        ST_PSD = 4'h7,
        ST_PLO = 4'h8,
        ST_PHI = 4'h9,
        ST_PEND = 4'ha
    } ime_state_type;

    typedef struct packed {
        ime_state_type st;
        logic [6:0] bit_phase_counter;
        logic armed;
        logic [3:0] bitc;
        logic [7:0] sr;
        logic [7:0] tbuf;
        logic [6:0] rld;
        logic ack_stat;
        logic ack_dat;
        logic ack_en;
        logic rcv_en;
        logic stp_en;
        logic bf;
        logic evt;
        logic write_collision_flag;
        logic ov;
        logic stopd;
        logic [7:0] rdata;
        logic sda_oe;
        logic scl_oe;
        logic sda_o;
        logic scl_o;
        logic [2:0] sda_s;
        logic [2:0] scl_s;
        logic sda_f;
        logic scl_f;
    } ime_regs_type;

    localparam ime_regs_type REGS_RST = '{
        st: ST_IDLE,
        rld: RLD_RST,
        sda_s: SYNC_RST,
        scl_s: SYNC_RST,
        sda_f: 1'b1,
        scl_f: 1'b1,
        default: '0
    };

endpackage : ime_pkg

// ### core/ime_byte_engine.sv
module ime_byte_engine (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CE,
    // register port
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // two-wire pins
    input wire logic SDA_PIN,
    output logic SDA_DRV,
    output logic SDA_EN,
    input wire logic SCL_PIN,
    output logic SCL_DRV,
    output logic SCL_EN
);

    // ********************************
    // state
    // ********************************
    ime_pkg::ime_regs_type st_r;
    ime_pkg::ime_regs_type st_nxt;

    logic tmo;
    logic idle;
    logic is_lo;
    logic is_hi;
    logic hi_to;
    logic is_tx;
    logic wr_buf;
    logic wr_ctl;

    assign tmo = (st_r.bit_phase_counter == 7'h00);
    assign idle = (st_r.st == ime_pkg::ST_IDLE);
    assign is_tx = (st_r.st == ime_pkg::ST_TXL) || (st_r.st == ime_pkg::ST_TXH);
    assign is_lo = (st_r.st == ime_pkg::ST_TXL) || (st_r.st == ime_pkg::ST_RXL)
                || (st_r.st == ime_pkg::ST_AKL) || (st_r.st == ime_pkg::ST_PLO);
    assign is_hi = (st_r.st == ime_pkg::ST_TXH) || (st_r.st == ime_pkg::ST_RXH)
                || (st_r.st == ime_pkg::ST_AKH) || (st_r.st == ime_pkg::ST_PHI);
    assign hi_to = is_hi && st_r.armed && tmo;
    assign wr_buf = WR && (ADDR == ime_pkg::ADR_BUF);
    assign wr_ctl = WR && (ADDR == ime_pkg::ADR_CTL);

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_nxt = st_r;
        if (CE) begin
            // sample pins
            // a level counts once the second and third stage agree
            st_nxt.sda_s = {st_r.sda_s[1:0], SDA_PIN};
            st_nxt.scl_s = {st_r.scl_s[1:0], SCL_PIN};
            if (st_r.sda_s[1] == st_r.sda_s[2]) begin
                st_nxt.sda_f = st_r.sda_s[1];
            end
            if (st_r.scl_s[1] == st_r.scl_s[2]) begin
                st_nxt.scl_f = st_r.scl_s[1];
            end

            // register reads: data stand for one cycle only
            st_nxt.rdata = 8'h00;
            if (RD) begin
                case (ADDR)
                    ime_pkg::ADR_BUF: st_nxt.rdata = st_r.tbuf;
                    ime_pkg::ADR_RLD: st_nxt.rdata = {1'b0, st_r.rld};
                    ime_pkg::ADR_CTL: st_nxt.rdata = {1'b0, st_r.ack_stat, st_r.ack_dat, st_r.ack_en,
                                                      st_r.rcv_en, st_r.stp_en, 2'h0};
                    default: st_nxt.rdata = {3'h0, st_r.stopd, st_r.ov, st_r.write_collision_flag, st_r.evt, st_r.bf};
                endcase
                if ((ADDR == ime_pkg::ADR_BUF) && !is_tx) begin
                    st_nxt.bf = 1'b0;
                end
            end

            // register writes
            if (WR) begin
                case (ADDR)
                    ime_pkg::ADR_BUF: begin
                        if (idle) begin
                            st_nxt.tbuf = WDATA;
                            st_nxt.sr = WDATA;
                            st_nxt.bf = 1'b1;
                            st_nxt.stopd = 1'b0;
                            st_nxt.bitc = 4'h0;
                            st_nxt.bit_phase_counter = st_r.rld;
                            st_nxt.scl_oe = 1'b1;
                            st_nxt.st = ime_pkg::ST_TXL;
                        end else begin
                            st_nxt.write_collision_flag = 1'b1;
                        end
                    end
                    ime_pkg::ADR_RLD: st_nxt.rld = WDATA[6:0];
                    ime_pkg::ADR_CTL: begin
                        st_nxt.ack_dat = WDATA[ime_pkg::C_AKD];
                        if (idle && WDATA[ime_pkg::C_STP]) begin
                            st_nxt.stp_en = 1'b1;
                            st_nxt.sda_oe = 1'b1;
                            st_nxt.scl_oe = 1'b1;
                            st_nxt.st = ime_pkg::ST_PSD;
                        end else if (idle && WDATA[ime_pkg::C_ACK]) begin
                            st_nxt.ack_en = 1'b1;
                            st_nxt.bit_phase_counter = st_r.rld;
                            st_nxt.scl_oe = 1'b1;
                            st_nxt.st = ime_pkg::ST_AKL;
                        end else if (idle && WDATA[ime_pkg::C_RCV]) begin
                            st_nxt.rcv_en = 1'b1;
                            st_nxt.bitc = 4'h0;
                            st_nxt.bit_phase_counter = st_r.rld;
                            st_nxt.sda_oe = 1'b0;
                            st_nxt.scl_oe = 1'b1;
                            st_nxt.st = ime_pkg::ST_RXL;
                        end
                    end
                    default: begin
                        // software clears event, collision and overflow
                        // write one to clear; hardware sets below win
                        st_nxt.evt = st_r.evt & ~WDATA[ime_pkg::S_EVT];
                        st_nxt.write_collision_flag = st_r.write_collision_flag & ~WDATA[ime_pkg::S_WRITE_COLLISION_FLAG];
                        st_nxt.ov = st_r.ov & ~WDATA[ime_pkg::S_OV];
                    end
                endcase
            end

            if (is_lo && !tmo) begin
                st_nxt.bit_phase_counter = st_r.bit_phase_counter - 7'h01;
            end
            if (is_hi) begin
                if (!st_r.armed) begin
                    if (st_r.scl_f) begin
                        st_nxt.armed = 1'b1;
                        st_nxt.bit_phase_counter = st_r.rld;
                    end
                end else if (!tmo) begin
                    st_nxt.bit_phase_counter = st_r.bit_phase_counter - 7'h01;
                end
            end

            unique case (st_r.st)
                ime_pkg::ST_IDLE: begin
                end
                ime_pkg::ST_TXL: begin
                    st_nxt.sda_oe = (st_r.bitc != ime_pkg::BIT_ACK) && !st_r.sr[7];
                    // with reload 0 the bit would move as SCL rises: hold the release one cycle
                    if (tmo && (st_r.sda_oe == st_nxt.sda_oe)) begin
                        st_nxt.scl_oe = 1'b0;
                        st_nxt.armed = 1'b0;
                        st_nxt.st = ime_pkg::ST_TXH;
                    end
                end
                ime_pkg::ST_TXH: begin
                    if (hi_to) begin
                        st_nxt.scl_oe = 1'b1;
                        st_nxt.bit_phase_counter = st_r.rld;
                        if (st_r.bitc == ime_pkg::BIT_ACK) begin
                            st_nxt.ack_stat = st_r.sda_f;
                            st_nxt.evt = 1'b1;
                            st_nxt.st = ime_pkg::ST_IDLE;
                        end else begin
                            if (st_r.bitc == ime_pkg::BIT_LAST) begin
                                st_nxt.bf = 1'b0;
                            end
                            st_nxt.sr = {st_r.sr[6:0], 1'b0};
                            st_nxt.bitc = st_r.bitc + 4'h1;
                            st_nxt.st = ime_pkg::ST_TXL;
                        end
                    end
                end
                ime_pkg::ST_RXL: begin
                    if (tmo) begin
                        st_nxt.scl_oe = 1'b0;
                        st_nxt.armed = 1'b0;
                        st_nxt.st = ime_pkg::ST_RXH;
                    end
                end
                ime_pkg::ST_RXH: begin
                    if (hi_to) begin
                        st_nxt.sr = {st_r.sr[6:0], st_r.sda_f};
                        st_nxt.scl_oe = 1'b1;
                        st_nxt.bit_phase_counter = st_r.rld;
                        st_nxt.bitc = st_r.bitc + 4'h1;
                        st_nxt.st = ime_pkg::ST_RXL;
                        if (st_r.bitc == ime_pkg::BIT_LAST) begin
                            st_nxt.rcv_en = 1'b0;
                            st_nxt.tbuf = {st_r.sr[6:0], st_r.sda_f};
                            st_nxt.bf = 1'b1;
                            st_nxt.evt = 1'b1;
                            st_nxt.st = ime_pkg::ST_IDLE;
                            if (st_r.bf) begin
                                st_nxt.ov = 1'b1;
                            end
                        end
                    end
                end
                ime_pkg::ST_AKL: begin
                    st_nxt.sda_oe = !st_r.ack_dat;
                    // ack level must settle before SCL is released
                    if (tmo && (st_r.sda_oe == st_nxt.sda_oe)) begin
                        st_nxt.scl_oe = 1'b0;
                        st_nxt.armed = 1'b0;
                        st_nxt.st = ime_pkg::ST_AKH;
                    end
                end
                ime_pkg::ST_AKH: begin
                    if (hi_to) begin
                        st_nxt.scl_oe = 1'b1;
                        st_nxt.ack_en = 1'b0;
                        st_nxt.st = ime_pkg::ST_IDLE;
                    end
                end
                ime_pkg::ST_PSD: begin
                    if (!st_r.sda_f) begin
                        st_nxt.bit_phase_counter = st_r.rld;
                        st_nxt.st = ime_pkg::ST_PLO;
                    end
                end
                ime_pkg::ST_PLO: begin
                    if (tmo) begin
                        st_nxt.scl_oe = 1'b0;
                        st_nxt.armed = 1'b0;
                        st_nxt.st = ime_pkg::ST_PHI;
                    end
                end
                ime_pkg::ST_PHI: begin
                    if (hi_to) begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.armed = 1'b0;
                        st_nxt.st = ime_pkg::ST_PEND;
                    end
                end
                ime_pkg::ST_PEND: begin
                    if (!st_r.armed) begin
                        if (st_r.sda_f && st_r.scl_f) begin
                            st_nxt.stopd = 1'b1;
                            st_nxt.armed = 1'b1;
                            st_nxt.bit_phase_counter = st_r.rld;
                        end
                    end else if (tmo) begin
                        st_nxt.stp_en = 1'b0;
                        st_nxt.evt = 1'b1;
                        st_nxt.st = ime_pkg::ST_IDLE;
                    end else begin
                        st_nxt.bit_phase_counter = st_r.bit_phase_counter - 7'h01;
                    end
                end
                default: begin
                    // illegal code: fall back to idle
                    st_nxt.st = ime_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            st_r <= ime_pkg::REGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // open drain only
    assign SDA_DRV = st_r.sda_o;
    assign SCL_DRV = st_r.scl_o;
    assign SDA_EN = st_r.sda_oe;
    assign SCL_EN = st_r.scl_oe;
    assign RDATA = st_r.rdata;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST || !CE);

    logic tx_fin;
    logic rx_fin;
    assign tx_fin = hi_to && (st_r.st == ime_pkg::ST_TXH) && (st_r.bitc == ime_pkg::BIT_ACK);
    assign rx_fin = hi_to && (st_r.st == ime_pkg::ST_RXH) && (st_r.bitc == ime_pkg::BIT_LAST);

    a_buf_start: assert property (wr_buf && idle |=> st_r.bf && st_r.scl_oe && st_r.st == ime_pkg::ST_TXL)
        else $error("buffer write did not start transmit");
    a_sda_after_scl: assert property (is_tx && $changed(st_r.sda_oe) |-> st_r.scl_oe && $past(st_r.scl_oe))
        else $error("SDA changed while SCL released");
    a_bf_eighth: assert property (hi_to && is_tx && st_r.bitc == ime_pkg::BIT_LAST |=> !st_r.bf ##1 !st_r.sda_oe)
        else $error("full flag or SDA not released after eighth bit");
    a_ack_sample: assert property (tx_fin |=> st_r.ack_stat == $past(st_r.sda_f))
        else $error("acknowledge status not sampled");
    a_tx_halt: assert property (tx_fin |=> st_r.evt && idle && st_r.scl_oe && !st_r.sda_oe)
        else $error("no event or halt after ninth clock");
    a_addr_shift: assert property (hi_to && is_tx && st_r.bitc < ime_pkg::BIT_LAST |=> st_r.sr[7] == $past(st_r.sr[6]))
        else $error("bit order wrong");
    a_write_collision_flag_tx: assert property (wr_buf && is_tx |=> st_r.write_collision_flag && st_r.tbuf == $past(st_r.tbuf))
        else $error("write during transmit not refused");
    a_write_collision_flag_keep: assert property (st_r.write_collision_flag && !(WR && ADDR == ime_pkg::ADR_STA) |=> st_r.write_collision_flag)
        else $error("collision flag cleared by hardware");
    a_rcv_ignore: assert property (wr_ctl && !idle && !st_r.rcv_en |=> !st_r.rcv_en)
        else $error("receive enable taken while busy");
    a_rx_shift: assert property (hi_to && st_r.st == ime_pkg::ST_RXH |=> st_r.sr[0] == $past(st_r.sda_f) && st_r.scl_oe)
        else $error("received bit not shifted");
    a_rx_done: assert property (rx_fin |=> !st_r.rcv_en && st_r.bf && st_r.evt && idle && st_r.tbuf == st_r.sr)
        else $error("receive completion wrong");
    a_rd_clear: assert property (RD && ADDR == ime_pkg::ADR_BUF && idle |=> !st_r.bf)
        else $error("buffer read did not clear full");
    a_overflow: assert property (rx_fin && st_r.bf |=> st_r.ov)
        else $error("overflow not flagged");
    a_write_collision_flag_rx: assert property (wr_buf && st_r.rcv_en && !rx_fin |=> st_r.write_collision_flag && st_r.tbuf == $past(st_r.tbuf))
        else $error("write during receive not refused");
    a_ack_drive: assert property (st_r.st == ime_pkg::ST_AKL |-> st_r.scl_oe ##1 st_r.sda_oe == !$past(st_r.ack_dat))
        else $error("ack data not driven");
    a_ack_end: assert property (hi_to && st_r.st == ime_pkg::ST_AKH |=> !st_r.ack_en && idle && st_r.scl_oe)
        else $error("acknowledge did not end");
    a_write_collision_flag_ack: assert property (wr_buf && st_r.ack_en |=> st_r.write_collision_flag && st_r.tbuf == $past(st_r.tbuf))
        else $error("write during acknowledge not refused");
    a_stop_sda: assert property (st_r.st == ime_pkg::ST_PSD && !st_r.sda_f |=> st_r.sda_oe && st_r.bit_phase_counter == st_r.rld)
        else $error("stop did not start count with SDA low");
    a_stop_seen: assert property (st_r.st == ime_pkg::ST_PEND && !st_r.armed && st_r.sda_f && st_r.scl_f
        |=> st_r.stopd && st_r.stp_en)
        else $error("stop detect not flagged");
    a_write_collision_flag_stop: assert property (wr_buf && st_r.stp_en |=> st_r.write_collision_flag && st_r.tbuf == $past(st_r.tbuf))
        else $error("write during stop not refused");
    a_brg_count: assert property (is_lo && !tmo && !WR |=> st_r.bit_phase_counter == $past(st_r.bit_phase_counter) - 7'h01)
        else $error("counter did not count down");
    a_brg_pause: assert property (is_hi && !st_r.armed && !st_r.scl_f |=> st_r.bit_phase_counter == $past(st_r.bit_phase_counter))
        else $error("counter ran with SCL held low");
    a_open_drain: assert property (!SDA_DRV && !SCL_DRV)
        else $error("pin driven high");

    c_tx_byte: cover property (tx_fin);
    c_rx_byte: cover property (rx_fin);
    c_stop: cover property (st_r.st == ime_pkg::ST_PEND && st_r.armed && tmo);
    c_ack: cover property (hi_to && st_r.st == ime_pkg::ST_AKH);

endmodule : ime_byte_engine

// ### testbench/ime_slave.sv
module ime_slave (
    // clock
    input wire logic clk,
    // resolved wire levels
    input wire logic scl,
    input wire logic sda,
    // behaviour chosen by the bench
    input wire logic clr,
    input wire logic mode_rd,
    input wire logic ack,
    input wire logic [7:0] rd_byte,
    input wire logic [3:0] stretch,
    // pulls and capture
    output logic sda_pull,
    output logic scl_pull,
    output logic [8:0] got
);
    timeunit 1ns;
    timeprecision 100ps;
    logic scl_q;
    logic [3:0] rcnt;
    logic [3:0] scnt;
    assign scl_pull = scnt != 4'h0;
    always @(posedge clk) begin
        scl_q <= scl;
        if (clr) begin
            rcnt <= 4'h0;
            scnt <= 4'h0;
            sda_pull <= 1'b0;
        end else begin
            if (scl && !scl_q) begin
                rcnt <= rcnt + 4'h1;
                got <= {got[7:0], sda};
            end
            // a slow slave holds the low phase longer after every falling edge
            if (!scl && scl_q) begin
                scnt <= stretch;
            end else if (scl_pull) begin
                scnt <= scnt - 4'h1;
            end
            // data moves only while the clock is low, so no false start or stop appears
            if (!scl) begin
                if (mode_rd) begin
                    sda_pull <= rcnt < 4'h8 && !rd_byte[3'h7 - rcnt[2:0]];
                end else begin
                    sda_pull <= ack && rcnt == 4'h8;
                end
            end
        end
    end
endmodule : ime_slave

// ### testbench/ime_byte_engine_tb.sv
`define CHK(w, e, s) \
    begin \
        n_tests++; \
        if ((s) !== (e)) begin \
            n_errors++; \
            $display("unexpected %s: expected %h seen %h", w, e, s); \
        end \
    end
module ime_byte_engine_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WATCH_NS = 200000;
    localparam logic [7:0] M_BF = 8'h01 << ime_pkg::S_BF;
    localparam logic [7:0] M_EVT = 8'h01 << ime_pkg::S_EVT;
    localparam logic [7:0] M_WRITE_COLLISION_FLAG = 8'h01 << ime_pkg::S_WRITE_COLLISION_FLAG;
    localparam logic [7:0] M_OV = 8'h01 << ime_pkg::S_OV;
    localparam logic [7:0] M_STOP = 8'h01 << ime_pkg::S_STOP;
    int n_errors = 0;
    int n_tests = 0;
    logic clk, srst, wr_s, rd_s, sda_o, sda_oe, scl_o, scl_oe, sda_w, scl_w, sda_pull, scl_pull;
    logic s_clr, s_rd, s_ack, ce;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, s_byte;
    logic [3:0] s_str;
    logic [8:0] got;
    // open-drain wires with pull-ups
    assign scl_w = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
    assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
    ime_byte_engine DUT (.REF_CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .SDA_PIN(sda_w), .SDA_DRV(sda_o), .SDA_EN(sda_oe), .SCL_PIN(scl_w),
        .SCL_DRV(scl_o), .SCL_EN(scl_oe));
    ime_slave slave (.clk(clk), .scl(scl_w), .sda(sda_w), .clr(s_clr), .mode_rd(s_rd), .ack(s_ack),
        .rd_byte(s_byte), .stretch(s_str), .sda_pull(sda_pull), .scl_pull(scl_pull), .got(got));
    // ********************************
    // bus tasks
    // ********************************
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic wait_bit(input logic [1:0] a, input int b, input logic v);
        logic [7:0] d;
        d = {8{~v}};
        for (int i = 0; i < 300 && d[b] !== v; i++) rd(a, d);
        `CHK("completion", v, d[b])
    endtask : wait_bit
    task automatic prep(input logic rdm, input logic ak, input logic [7:0] b, input logic [3:0] st);
        @(posedge clk);
        s_rd <= rdm;
        s_ack <= ak;
        s_byte <= b;
        s_str <= st;
        s_clr <= 1'b1;
        @(posedge clk);
        s_clr <= 1'b0;
        wr(ime_pkg::ADR_STA, M_EVT | M_WRITE_COLLISION_FLAG | M_OV);
    endtask : prep
    // ********************************
    // scenarios
    // ********************************
    task automatic t_tx(input logic [7:0] b, input logic ak, input logic [3:0] st);
        logic [7:0] d;
        prep(1'b0, ak, 8'h00, st);
        wr(ime_pkg::ADR_BUF, b);
        rd(ime_pkg::ADR_STA, d);
        `CHK("full on write", 1'b1, d[ime_pkg::S_BF])
        wr(ime_pkg::ADR_BUF, ~b);
        wr(ime_pkg::ADR_CTL, 8'h08);
        rd(ime_pkg::ADR_CTL, d);
        `CHK("receive while busy", 1'b0, d[ime_pkg::C_RCV])
        wait_bit(ime_pkg::ADR_STA, ime_pkg::S_EVT, 1'b1);
        `CHK("wire bits", {b, ~ak}, got)
        rd(ime_pkg::ADR_STA, d);
        `CHK("tx status", M_EVT | M_WRITE_COLLISION_FLAG, d)
        rd(ime_pkg::ADR_CTL, d);
        `CHK("ack status", ~ak, d[ime_pkg::C_AKS])
        `CHK("pins after byte", 2'b10, {scl_oe, sda_oe})
        wr(ime_pkg::ADR_STA, M_WRITE_COLLISION_FLAG);
        rd(ime_pkg::ADR_STA, d);
        `CHK("collision cleared", 1'b0, d[ime_pkg::S_WRITE_COLLISION_FLAG])
        rd(ime_pkg::ADR_BUF, d);
        `CHK("buffer kept", b, d)
    endtask : t_tx
    task automatic rx_one(input logic [7:0] b);
        prep(1'b1, 1'b0, b, 4'h0);
        wr(ime_pkg::ADR_CTL, 8'h08);
        wr(ime_pkg::ADR_BUF, 8'hff);
        wait_bit(ime_pkg::ADR_STA, ime_pkg::S_EVT, 1'b1);
    endtask : rx_one
    task automatic t_rx();
        logic [7:0] d;
        rx_one(8'hc3);
        rd(ime_pkg::ADR_CTL, d);
        `CHK("receive done", 1'b0, d[ime_pkg::C_RCV])
        rd(ime_pkg::ADR_STA, d);
        `CHK("rx status", M_BF | M_EVT | M_WRITE_COLLISION_FLAG, d)
        rx_one(8'h96);
        rd(ime_pkg::ADR_STA, d);
        `CHK("overflow status", M_BF | M_EVT | M_WRITE_COLLISION_FLAG | M_OV, d)
        rd(ime_pkg::ADR_BUF, d);
        `CHK("rx byte", 8'h96, d)
        rd(ime_pkg::ADR_STA, d);
        `CHK("full after read", 1'b0, d[ime_pkg::S_BF])
    endtask : t_rx
    task automatic t_ack();
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            prep(1'b0, 1'b0, 8'h00, 4'h0);
            wr(ime_pkg::ADR_CTL, 8'h10 | (8'(i) << ime_pkg::C_AKD));
            wr(ime_pkg::ADR_BUF, 8'h00);
            wait_bit(ime_pkg::ADR_CTL, ime_pkg::C_ACK, 1'b0);
            `CHK("ack level", 1'(i), got[0])
            `CHK("scl low after ack", 1'b1, scl_oe)
            rd(ime_pkg::ADR_STA, d);
            `CHK("ack collision", 1'b1, d[ime_pkg::S_WRITE_COLLISION_FLAG])
            rd(ime_pkg::ADR_BUF, d);
            `CHK("ack buffer kept", 8'h96, d)
        end
    endtask : t_ack
    task automatic t_stop();
        logic [7:0] d;
        prep(1'b0, 1'b0, 8'h00, 4'h0);
        wr(ime_pkg::ADR_CTL, 8'h04);
        wr(ime_pkg::ADR_BUF, 8'h00);
        wait_bit(ime_pkg::ADR_STA, ime_pkg::S_EVT, 1'b1);
        rd(ime_pkg::ADR_STA, d);
        `CHK("stop status", M_STOP | M_EVT | M_WRITE_COLLISION_FLAG, d)
        rd(ime_pkg::ADR_CTL, d);
        `CHK("stop enable", 1'b0, d[ime_pkg::C_STP])
        `CHK("wire idle", 4'h3, {scl_oe, sda_oe, scl_w, sda_w})
        `CHK("drive levels", 2'b00, {scl_o, sda_o})
        rd(ime_pkg::ADR_BUF, d);
        `CHK("stop buffer kept", 8'h96, d)
    endtask : t_stop
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #(WATCH_NS);
        n_errors++;
        results();
    end
    initial begin
        logic [7:0] d;
        srst = 1'b1;
        addr = 2'h0;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        s_clr = 1'b1;
        s_rd = 1'b0;
        s_ack = 1'b0;
        s_byte = 8'h00;
        s_str = 4'h0;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd(ime_pkg::ADR_RLD, d);
        `CHK("reload reset", {1'b0, ime_pkg::RLD_RST}, d)
        rd(ime_pkg::ADR_STA, d);
        `CHK("status reset", 8'h00, d)
        wr(ime_pkg::ADR_RLD, 8'h83);
        rd(ime_pkg::ADR_RLD, d);
        `CHK("reload bits", 8'h03, d)
        // a write made while the enable is low must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        wr(ime_pkg::ADR_RLD, 8'h7f);
        ce <= 1'b1;
        rd(ime_pkg::ADR_RLD, d);
        `CHK("frozen reload", 8'h03, d)
        t_tx(8'ha5, 1'b1, 4'h0);
        t_tx(8'h5a, 1'b0, 4'h6);
        t_rx();
        t_ack();
        t_stop();
        results();
    end
endmodule : ime_byte_engine_tb
